// ==== asbl_pkg.sv ====
// package: constants and carrier types for the asynchronous sram host controller
package asbl_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int ASBL_ADDR_W = 18;
  localparam int ASBL_DATA_W = 16;
  localparam int ASBL_SYNC_STAGES = 3;

  // ***************************************************************
  // timing: figures in their own unit, then cycle counts at 100 mhz
  // ***************************************************************
  localparam int ASBL_CLK_PERIOD_PS = 10000;
  localparam int ASBL_SUPPLY_SETTLE_WAIT_US = 100;
  localparam int ASBL_ADDRESS_ACCESS_DELAY_NS = 10;
  localparam int ASBL_READ_CYCLE_MIN_NS = 10;
  localparam int ASBL_WRITE_CYCLE_MIN_NS = 10;
  localparam int ASBL_ADDRESS_TO_WRITE_END_NS = 7;
  localparam int ASBL_STROBE_TO_FLOAT_DELAY_NS = 5;
  localparam int ASBL_DATA_SETUP_TO_END_NS = 5;
  localparam int ASBL_READ_DATA_HOLD_NS = 3;
  localparam int ASBL_STANDBY_ENTRY_NS = 10;
  // one extra cycle of margin for pad and board skew on the read, access, write overlap, write and turnaround counts; none on the setup span or supply wait
  localparam int ASBL_MARGIN_CYC = 1;

  function automatic int asbl_min_cyc(input int ns);
    int c;
    c = (ns * 1000 + ASBL_CLK_PERIOD_PS - 1) / ASBL_CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : asbl_min_cyc

  localparam int ASBL_SUPPLY_SETTLE_CYC =
    (ASBL_SUPPLY_SETTLE_WAIT_US * 1000000 + ASBL_CLK_PERIOD_PS - 1) / ASBL_CLK_PERIOD_PS;
  localparam int ASBL_READ_CYC = asbl_min_cyc(ASBL_READ_CYCLE_MIN_NS) + ASBL_MARGIN_CYC;
  localparam int ASBL_ACCESS_CYC =
    asbl_min_cyc(ASBL_ADDRESS_ACCESS_DELAY_NS) + ASBL_MARGIN_CYC;
  localparam int ASBL_WRITE_OVL_CYC =
    asbl_min_cyc(ASBL_ADDRESS_TO_WRITE_END_NS) + ASBL_MARGIN_CYC;
  localparam int ASBL_WRITE_CYC = asbl_min_cyc(ASBL_WRITE_CYCLE_MIN_NS) + ASBL_MARGIN_CYC;
  localparam int ASBL_TURN_CYC =
    asbl_min_cyc(ASBL_STROBE_TO_FLOAT_DELAY_NS + ASBL_DATA_SETUP_TO_END_NS) + ASBL_MARGIN_CYC;
  localparam int ASBL_SETUP_CYC = asbl_min_cyc(ASBL_DATA_SETUP_TO_END_NS);
  localparam int ASBL_CNT_W = 8;
  localparam logic [ASBL_CNT_W-1:0] ASBL_CNT_ZERO = 8'h00;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [ASBL_ADDR_W-1:0] addr;
    logic [ASBL_DATA_W-1:0] wdata;
    logic [1:0] lane_n;
  } asbl_req_t;

  typedef struct packed {
    logic chip_sel_n;
    logic out_drive_n;
    logic write_n;
    logic low_byte_lane_n;
    logic high_byte_lane_n;
    logic [ASBL_ADDR_W-1:0] addr;
    logic [ASBL_DATA_W-1:0] dq_out;
    logic [ASBL_DATA_W-1:0] dq_oe;
  } asbl_pins_t;

  typedef enum {
    ASBL_ST_POWER,
    ASBL_ST_IDLE,
    ASBL_ST_READ,
    ASBL_ST_WR_SETUP,
    ASBL_ST_WR_STROBE,
    ASBL_ST_WR_RECOVER
  } asbl_state_t;

endpackage : asbl_pkg

// ==== asbl_sync.sv ====
// file: three-stage synchroniser for a WIDTH-bit pin input
`timescale 1ns/10ps
module asbl_sync
  import asbl_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } asbl_sync_state_t;

  asbl_sync_state_t st_reg;
  asbl_sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a bit counts once second and third stages agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.out[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.out;

endmodule : asbl_sync

// ==== asbl_host.sv ====
// file: host controller that drives an asynchronous 16-bit byte-lane sram
// ***************************************************************
// ***************************************************************
`timescale 1ns/10ps
module asbl_host
  import asbl_pkg::*;
#(
  parameter int SUPPLY_SETTLE_CYC = ASBL_SUPPLY_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire asbl_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [ASBL_DATA_W-1:0] rsp_rdata_o,
  output logic busy_o,
  output asbl_pins_t pins_o,
  input wire logic [ASBL_DATA_W-1:0] dq_i
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    asbl_state_t fsm;
    logic [16:0] power_cnt;
    logic [ASBL_CNT_W-1:0] cnt;
    asbl_pins_t pins;
    logic rsp_valid;
    logic [ASBL_DATA_W-1:0] rdata;
  } asbl_host_state_t;

  asbl_host_state_t st_reg;
  asbl_host_state_t st_next;
  logic [ASBL_DATA_W-1:0] dq_sync;

  asbl_sync #(
    .WIDTH(ASBL_DATA_W)
  ) u_dq_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(dq_i),
    .sync_o(dq_sync)
  );

  // ***************************************************************
  // sequencing
  // ***************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;
    case (st_reg.fsm)
      ASBL_ST_POWER: begin
        st_next.pins.chip_sel_n = 1'b1;
        if (st_reg.power_cnt >= 17'(SUPPLY_SETTLE_CYC - 1)) begin
          st_next.fsm = ASBL_ST_IDLE;
        end else begin
          st_next.power_cnt = st_reg.power_cnt + 17'h00001;
        end
      end
      ASBL_ST_IDLE: begin
        st_next.pins.chip_sel_n = 1'b1;
        st_next.pins.out_drive_n = 1'b1;
        st_next.pins.write_n = 1'b1;
        st_next.pins.low_byte_lane_n = 1'b1;
        st_next.pins.high_byte_lane_n = 1'b1;
        st_next.pins.dq_oe = '0;
        if (req_i.valid) begin
          // address goes out with chip select falling
          st_next.pins.addr = req_i.addr;
          st_next.pins.low_byte_lane_n = req_i.lane_n[0];
          st_next.pins.high_byte_lane_n = req_i.lane_n[1];
          st_next.cnt = ASBL_CNT_ZERO;
          if (req_i.write) begin
            // strobe follows data by a setup span; output drive stays high
            st_next.pins.chip_sel_n = 1'b0;
            st_next.pins.dq_out = req_i.wdata;
            st_next.pins.dq_oe = {{8{~req_i.lane_n[1]}}, {8{~req_i.lane_n[0]}}};
            st_next.fsm = ASBL_ST_WR_SETUP;
          end else begin
            st_next.pins.chip_sel_n = 1'b0;
            st_next.pins.out_drive_n = 1'b0;
            st_next.pins.write_n = 1'b1;
            st_next.fsm = ASBL_ST_READ;
          end
        end
      end
      ASBL_ST_READ: begin
        st_next.cnt = st_reg.cnt + 8'h01;
        // sample after access delay plus synchroniser latency
        if (st_reg.cnt == 8'(ASBL_ACCESS_CYC + ASBL_SYNC_STAGES)) begin
          st_next.rdata = dq_sync;
          st_next.rsp_valid = 1'b1;
          st_next.pins.chip_sel_n = 1'b1;
          st_next.pins.out_drive_n = 1'b1;
          st_next.pins.low_byte_lane_n = 1'b1;
          st_next.pins.high_byte_lane_n = 1'b1;
          st_next.fsm = ASBL_ST_IDLE;
        end
      end
      ASBL_ST_WR_SETUP: begin
        st_next.cnt = st_reg.cnt + 8'h01;
        if (st_reg.cnt == 8'(ASBL_SETUP_CYC - 1)) begin
          st_next.pins.write_n = 1'b0;
          st_next.cnt = ASBL_CNT_ZERO;
          st_next.fsm = ASBL_ST_WR_STROBE;
        end
      end
      ASBL_ST_WR_STROBE: begin
        st_next.cnt = st_reg.cnt + 8'h01;
        // overlap covers 7 ns and turnaround plus setup
        if (st_reg.cnt == 8'(((ASBL_WRITE_OVL_CYC > ASBL_TURN_CYC) ?
            ASBL_WRITE_OVL_CYC : ASBL_TURN_CYC) - 1)) begin
          st_next.pins.write_n = 1'b1;
          st_next.cnt = ASBL_CNT_ZERO;
          st_next.fsm = ASBL_ST_WR_RECOVER;
        end
      end
      ASBL_ST_WR_RECOVER: begin
        // data and address held one cycle past the terminating edge
        st_next.pins.chip_sel_n = 1'b1;
        st_next.pins.low_byte_lane_n = 1'b1;
        st_next.pins.high_byte_lane_n = 1'b1;
        st_next.pins.dq_oe = '0;
        st_next.fsm = ASBL_ST_IDLE;
      end
      default: begin
        st_next.fsm = ASBL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_reg.fsm <= ASBL_ST_POWER;
      st_reg.power_cnt <= 17'h00000;
      st_reg.cnt <= ASBL_CNT_ZERO;
      st_reg.pins <= '{chip_sel_n: 1'b1, out_drive_n: 1'b1, write_n: 1'b1,
                       low_byte_lane_n: 1'b1, high_byte_lane_n: 1'b1,
                       addr: '0, dq_out: '0, dq_oe: '0};
      st_reg.rsp_valid <= 1'b0;
      st_reg.rdata <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign req_ready_o = (st_reg.fsm == ASBL_ST_IDLE);
  assign busy_o = (st_reg.fsm != ASBL_ST_IDLE);
  assign rsp_valid_o = st_reg.rsp_valid;
  assign rsp_rdata_o = st_reg.rdata;
  assign pins_o = st_reg.pins;

endmodule : asbl_host

// ==== asbl_host_checker.sv ====
// checker: pin timing relations of the sram host controller
`timescale 1ns/10ps
module asbl_host_checker
  import asbl_pkg::*;
#(
  parameter int SUPPLY_SETTLE_CYC = ASBL_SUPPLY_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire asbl_pins_t pins_o
);
  logic [15:0] up_reg;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      up_reg <= 16'h0000;
    end else if (up_reg != 16'hffff) begin
      up_reg <= up_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  settle_wait_a: assert property (req_ready_o |-> up_reg >= SUPPLY_SETTLE_CYC)
    else $error("ready before power wait");
  write_gated_a: assert property (!pins_o.write_n |-> !pins_o.chip_sel_n &&
    !(pins_o.low_byte_lane_n && pins_o.high_byte_lane_n)) else $error("strobe without select");
  write_overlap_a: assert property ($fell(pins_o.write_n) |-> !pins_o.write_n [*2])
    else $error("write strobe too short");
  data_hold_a: assert property ($rose(pins_o.write_n) |-> $stable(pins_o.dq_out) &&
    $stable(pins_o.addr) && pins_o.dq_oe != 16'h0000) else $error("data moved at write end");
  no_clash_a: assert property (!pins_o.out_drive_n |-> pins_o.write_n &&
    pins_o.dq_oe == 16'h0000) else $error("drive clash during read");
  read_answer_a: assert property ($fell(pins_o.out_drive_n) |->
    (!pins_o.out_drive_n && !pins_o.chip_sel_n) [*6] ##1 rsp_valid_o)
    else $error("read answer misplaced");
  addr_stable_a: assert property (!pins_o.chip_sel_n && !$past(pins_o.chip_sel_n) |->
    $stable(pins_o.addr)) else $error("address moved while selected");
  idle_quiet_a: assert property (req_ready_o |-> pins_o.chip_sel_n && pins_o.write_n &&
    pins_o.out_drive_n && pins_o.dq_oe == 16'h0000) else $error("pins active in idle");
endmodule : asbl_host_checker

bind asbl_host asbl_host_checker #(.SUPPLY_SETTLE_CYC(SUPPLY_SETTLE_CYC)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o), .pins_o(pins_o));

// ==== asbl_sram_model.sv ====
// model: behavioural byte-lane sram answering the host pins
`timescale 1ns/10ps
module asbl_sram_model
  import asbl_pkg::*;
#(
  parameter int DLY_NS = 9
) (
  input wire logic clk_i,
  input wire asbl_pins_t pins_i,
  output logic [ASBL_DATA_W-1:0] dq_o
);
  logic [ASBL_DATA_W-1:0] mem [0:255];
  logic [ASBL_DATA_W-1:0] bus;
  logic flt = 1'b0;
  wire sel = !pins_i.chip_sel_n;
  wire rd = sel && !pins_i.out_drive_n && pins_i.write_n;
  wire wr_lo = sel && !pins_i.write_n && !pins_i.low_byte_lane_n;
  wire wr_hi = sel && !pins_i.write_n && !pins_i.high_byte_lane_n;
  // released lines toggle so a stale value is never read as good
  always @(posedge clk_i) flt <= ~flt;
  always @* begin
    bus = 16'h5aa5 ^ {16{flt}};
    if (rd && !pins_i.low_byte_lane_n) bus[7:0] = mem[pins_i.addr[7:0]][7:0];
    if (rd && !pins_i.high_byte_lane_n) bus[15:8] = mem[pins_i.addr[7:0]][15:8];
    for (int i = 0; i < ASBL_DATA_W; i++) begin
      if (pins_i.dq_oe[i]) bus[i] = pins_i.dq_out[i];
    end
  end
  assign #(DLY_NS) dq_o = bus;
  always @(negedge wr_lo) mem[pins_i.addr[7:0]][7:0] = bus[7:0];
  always @(negedge wr_hi) mem[pins_i.addr[7:0]][15:8] = bus[15:8];
endmodule : asbl_sram_model

// ==== tb_asbl_host.sv ====
// testbench: host controller against a behavioural sram
`timescale 1ns/10ps
module tb_asbl_host;
  import asbl_pkg::*;
  localparam int SETTLE = 10;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  asbl_req_t req_i = '0;
  logic req_ready_o, rsp_valid_o, busy_o;
  logic [ASBL_DATA_W-1:0] rsp_rdata_o, dq_i;
  asbl_pins_t pins_o;
  int err_count = 0;
  int total_checks = 0;
  always #5 clk_i = ~clk_i;
  asbl_host #(.SUPPLY_SETTLE_CYC(SETTLE)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o), .pins_o(pins_o), .dq_i(dq_i));
  asbl_sram_model #(.DLY_NS(9)) u_mem (.clk_i(clk_i), .pins_i(pins_o), .dq_o(dq_i));
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic tick(inout int n);
    @(posedge clk_i);
    #1;
    n++;
    if (n > 200) begin
      $display("unexpected wait expected 0 seen 1");
      err_count++;
      results();
    end
  endtask : tick
  task automatic xfer(input logic wr, input logic [17:0] a, input logic [15:0] d,
    input logic [1:0] ln);
    int n;
    n = 0;
    req_i = '{valid: 1'b1, write: wr, addr: a, wdata: d, lane_n: ln};
    while (req_ready_o !== 1'b1) tick(n);
    @(posedge clk_i);
    #1;
    req_i.valid = 1'b0;
    chk("busy", 16'h0001, {15'h0000, busy_o});
    chk("addr low", a[15:0], pins_o.addr[15:0]);
    chk("addr high", {14'h0000, a[17:16]}, {14'h0000, pins_o.addr[17:16]});
    while (!wr && rsp_valid_o !== 1'b1) tick(n);
    // let a write finish so the next request is not raised as this one drops
    while (wr && req_ready_o !== 1'b1) tick(n);
  endtask : xfer
  task automatic t_settle();
    int n;
    n = 0;
    while (req_ready_o !== 1'b1) tick(n);
    chk("settle", 16'h0001, {15'h0000, n >= SETTLE});
  endtask : t_settle
  task automatic t_full();
    xfer(1'b1, 18'h00012, 16'hc3a5, 2'b00);
    xfer(1'b0, 18'h00012, 16'h0000, 2'b00);
    chk("full word", 16'hc3a5, rsp_rdata_o);
  endtask : t_full
  task automatic t_lanes();
    xfer(1'b1, 18'h00012, 16'h1177, 2'b10);
    xfer(1'b1, 18'h00012, 16'h66ee, 2'b01);
    xfer(1'b0, 18'h00012, 16'h0000, 2'b00);
    chk("merged word", 16'h6677, rsp_rdata_o);
    xfer(1'b0, 18'h00012, 16'h0000, 2'b10);
    chk("low lane", 16'h0077, {8'h00, rsp_rdata_o[7:0]});
    xfer(1'b0, 18'h00012, 16'h0000, 2'b01);
    chk("high lane", 16'h6600, {rsp_rdata_o[15:8], 8'h00});
  endtask : t_lanes
  task automatic t_back();
    xfer(1'b1, 18'h3ffff, 16'h0ff0, 2'b00);
    xfer(1'b1, 18'h00000, 16'hf00f, 2'b00);
    xfer(1'b0, 18'h3ffff, 16'h0000, 2'b00);
    chk("top word", 16'h0ff0, rsp_rdata_o);
    xfer(1'b0, 18'h00000, 16'h0000, 2'b00);
    chk("bottom word", 16'hf00f, rsp_rdata_o);
  endtask : t_back
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    t_settle();
    t_full();
    t_lanes();
    t_back();
    reset_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    t_settle();
    t_full();
    results();
  end
endmodule : tb_asbl_host
